//--- ltc_pkg.sv
package ltc_pkg;

    // sizes of the count path and the match slots
    localparam int LTC_CNT_W      = 24;
    localparam int LTC_PRE_W      = 12;
    localparam int LTC_SLOTS      = 4;
    localparam int LTC_SLOT_IDX_W = 2;

    // counter and prescale values
    localparam logic [LTC_CNT_W-1:0] LTC_CNT_RST   = 24'h000000;
    localparam logic [LTC_CNT_W-1:0] LTC_CNT_ONES  = 24'hffffff;
    localparam logic [LTC_CNT_W-1:0] LTC_NEAR_WRAP = 24'hfffff0;
    localparam logic [LTC_PRE_W-1:0] LTC_PRE_RST   = 12'h000;
    localparam logic [LTC_PRE_W-1:0] LTC_PRE_ZERO  = 12'h000;

    // timing in fast peripheral clock cycles
    localparam int LTC_RD_STALL_CYC  = 4;
    localparam int LTC_RD_TOTAL_CYC  = 6;
    localparam int LTC_CAP_DELAY_CYC = 6;
    localparam logic [2:0] LTC_RD_LAST = 3'(LTC_RD_STALL_CYC - 1);

    // gate bits and event pulses share one layout
    typedef struct packed {
        logic                 tick;
        logic                 wrap;
        logic [LTC_SLOTS-1:0] cmp;
    } ltc_evt_t;

    // task strobes, also used for the pending copies
    typedef struct packed {
        logic                 start;
        logic                 stop;
        logic                 clear;
        logic                 near_wrap;
        logic [LTC_SLOTS-1:0] capture;
    } ltc_task_t;

    // one stage of the capture delay line
    typedef struct packed {
        logic [LTC_SLOTS-1:0] vec;
        logic [LTC_CNT_W-1:0] val;
    } ltc_cap_t;

    typedef enum logic [1:0] {
        LTC_RD_IDLE,
        LTC_RD_STALL,
        LTC_RD_DONE
    } ltc_rd_state_t;

    // slot index to one-hot select
    function automatic logic [LTC_SLOTS-1:0] ltc_onehot(input logic [LTC_SLOT_IDX_W-1:0] idx);
        logic [LTC_SLOTS-1:0] sel;
        sel = '0;
        sel[idx] = 1'b1;
        return sel;
    endfunction : ltc_onehot

endpackage : ltc_pkg

//--- ltc_slot_mem.sv
`timescale 1ns/1ps
module ltc_slot_mem #(
    parameter int W  = 24,
    parameter int N  = 4,
    parameter int IW = 2
) (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    // write side, one enable per slot, shared data
    input  wire logic [N-1:0]   wr_vec,
    input  wire logic [W-1:0]   wr_data,
    // registered read port
    input  wire logic [IW-1:0]  rd_idx,
    output logic      [W-1:0]   rd_data,
    // every slot at once for the comparators
    output logic      [N*W-1:0] all_flat
);

    logic [W-1:0] slot_q [N];

    // each slot is its own register so the compare bank sees them all
    generate
        for (genvar i = 0; i < N; i++) begin : g_slot
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    slot_q[i] <= '0;
                end else if (wr_vec[i]) begin
                    slot_q[i] <= wr_data;
                end
            end
            assign all_flat[i*W +: W] = slot_q[i];
        end
    endgenerate

    // read data comes from a flop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= slot_q[rd_idx];
        end
    end

endmodule : ltc_slot_mem

//--- ltc_top.sv
`timescale 1ns/1ps
module ltc_top (
    // clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   sys_rst,
    // low-frequency clock pins
    input  wire logic                                   low_freq_clock,
    input  wire logic                                   low_freq_running,
    output logic                                        low_freq_request,
    output logic                                        low_freq_rc_source,
    // task strobes, one cycle each
    input  wire ltc_pkg::ltc_task_t                     task_in,
    // configuration
    input  wire logic [ltc_pkg::LTC_PRE_W-1:0]          prescale_wdata,
    input  wire logic                                   prescale_we,
    input  wire ltc_pkg::ltc_evt_t                      event_gate_enable,
    // match slot access
    input  wire logic                                   slot_wr_en,
    input  wire logic [ltc_pkg::LTC_SLOT_IDX_W-1:0]     slot_wr_idx,
    input  wire logic [ltc_pkg::LTC_CNT_W-1:0]          slot_wr_data,
    output logic                                        slot_wr_ready,
    input  wire logic [ltc_pkg::LTC_SLOT_IDX_W-1:0]     slot_rd_idx,
    output logic      [ltc_pkg::LTC_CNT_W-1:0]          slot_rd_data,
    // count read
    input  wire logic                                   cnt_rd_req,
    output logic                                        cnt_rd_stall,
    output logic                                        cnt_rd_ack,
    output logic      [ltc_pkg::LTC_CNT_W-1:0]          cnt_rd_data,
    // events and clock requests
    output ltc_pkg::ltc_evt_t                           evt_out,
    output logic                                        fast_peripheral_clock_req,
    output logic                                        high_freq_clock_req,
    // status
    output logic                                        running,
    output logic      [ltc_pkg::LTC_PRE_W-1:0]          prescale_setting
);
    import ltc_pkg::*;

    localparam int CAP_STAGES = LTC_CAP_DELAY_CYC - 1;

    logic                    lf_s1_q, lf_s2_q, lf_s3_q;
    logic                    lr_s1_q, lr_s2_q;
    logic                    lf_rise;
    ltc_task_t               pend_q, pend_d;
    logic [LTC_CNT_W-1:0]    cnt_q, cnt_d, cnt_inc;
    logic [LTC_PRE_W-1:0]    prescale_down_counter_q, prescale_down_counter_d, prescale_q;
    logic [LTC_PRE_W-1:0]    pdc_dec;
    logic                    pdc_zero, do_clear, do_near_wrap, wrap_hit;
    logic                    run_lf_q, run_lf_d;
    logic                    run_fast_q;
    logic                    restart, inc, fire, pre_ok;
    ltc_evt_t                evt_d, evt_q;
    logic                    lf_req_q, lf_rc_q;
    ltc_cap_t                cap_q [CAP_STAGES];
    ltc_cap_t                cap_last;
    logic                    cap_hit;
    logic [LTC_SLOTS-1:0]    mem_wr_vec;
    logic [LTC_CNT_W-1:0]    mem_wr_data;
    logic [LTC_SLOTS*LTC_CNT_W-1:0] slots_flat;
    ltc_rd_state_t           rd_st_q;
    logic [2:0]              rd_cnt_q;
    logic [LTC_CNT_W-1:0]    rd_data_q;

    // low clock and its running flag are pins: two flops before any use
    // the third flop only feeds the edge detect, so no logic reads the first stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
            lf_s3_q <= 1'b0;
            lr_s1_q <= 1'b0;
            lr_s2_q <= 1'b0;
        end else begin
            lf_s1_q <= low_freq_clock;
            lf_s2_q <= lf_s1_q;
            lf_s3_q <= lf_s2_q;
            lr_s1_q <= low_freq_running;
            lr_s2_q <= lr_s1_q;
        end
    end

    assign lf_rise = lf_s2_q & ~lf_s3_q;

    // pending tasks: a new task in the edge cycle waits for the next edge
    // strobes are held as levels because a one-cycle pulse would fall between slow edges
    assign pend_d = (lf_rise ? '0 : pend_q) | task_in;

    // restart the divider on start, clear and near-wrap
    assign restart = pend_q.start | pend_q.clear | pend_q.near_wrap;

    // counter loads and divider decodes that act on the synchronised edge
    assign do_clear     = lf_rise & pend_q.clear;
    assign do_near_wrap = lf_rise & pend_q.near_wrap;
    assign pdc_zero     = (prescale_down_counter_q == LTC_PRE_ZERO);
    assign pdc_dec      = prescale_down_counter_q - 1'b1;

    // stop still lets a due increment through on the same edge
    assign inc = lf_rise & run_lf_q & pdc_zero
               & ~pend_q.clear & ~pend_q.near_wrap;
    assign cnt_inc = cnt_q + 1'b1;

    // new count: clear, then near-wrap, then increment
    assign cnt_d = do_clear     ? LTC_CNT_RST   :
                   do_near_wrap ? LTC_NEAR_WRAP :
                   inc          ? cnt_inc       : cnt_q;

    // divide by setting plus one: count down, reload at zero
    assign prescale_down_counter_d = !lf_rise  ? prescale_down_counter_q :
                                     restart   ? prescale_q              :
                                     !run_lf_q ? prescale_down_counter_q :
                                     pdc_zero  ? prescale_q              : pdc_dec;

    // stop beats a start pending on the same edge
    // limitation: a start sent before an earlier stop has acted leaves the count stopped
    assign run_lf_d = !lf_rise    ? run_lf_q :
                      pend_q.stop ? 1'b0     :
                      pend_q.start ? 1'b1    : run_lf_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_q                  <= '0;
            cnt_q                   <= LTC_CNT_RST;
            prescale_down_counter_q <= LTC_PRE_RST;
            run_lf_q                <= 1'b0;
        end else begin
            pend_q                  <= pend_d;
            cnt_q                   <= cnt_d;
            prescale_down_counter_q <= prescale_down_counter_d;
            run_lf_q                <= run_lf_d;
        end
    end

    // setting is only written while both sides are stopped
    assign pre_ok = prescale_we & ~run_fast_q & ~run_lf_q;

    // fast-side run flag drops on stop so events die at once
    // the slow side only follows at the next synchronised edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            run_fast_q <= 1'b0;
            prescale_q <= LTC_PRE_RST;
        end else begin
            if (task_in.stop) begin
                run_fast_q <= 1'b0;
            end else if (task_in.start) begin
                run_fast_q <= 1'b1;
            end
            if (pre_ok) begin
                prescale_q <= prescale_wdata;
            end
        end
    end

    // clock request: RC source only if the clock was idle at start
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lf_req_q <= 1'b0;
            lf_rc_q  <= 1'b0;
        end else if (task_in.stop) begin
            lf_req_q <= 1'b0;
            lf_rc_q  <= 1'b0;
        end else if (task_in.start) begin
            lf_req_q <= 1'b1;
            lf_rc_q  <= ~lr_s2_q;
        end
    end

    // events: gated one by one, all muted once stop is seen
    assign fire        = inc & run_fast_q;
    assign evt_d.tick  = fire & event_gate_enable.tick;
    assign wrap_hit    = (cnt_q == LTC_CNT_ONES);
    assign evt_d.wrap  = fire & wrap_hit & event_gate_enable.wrap;

    // compares look only at increments, so captures never match
    generate
        for (genvar n = 0; n < LTC_SLOTS; n++) begin : g_cmp
            assign evt_d.cmp[n] = fire & event_gate_enable.cmp[n]
                                & (cnt_inc == slots_flat[n*LTC_CNT_W +: LTC_CNT_W]);
        end
    endgenerate

    // registered event pulses; only gated-on events ask for fast clocks
    // gated-off events never reach evt_d, so they cannot wake the fast clocks
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            evt_q                     <= '0;
            fast_peripheral_clock_req <= 1'b0;
            high_freq_clock_req       <= 1'b0;
        end else begin
            evt_q                     <= evt_d;
            fast_peripheral_clock_req <= |evt_d;
            high_freq_clock_req       <= |evt_d;
        end
    end

    // capture delay line: value taken at the trigger, before any clear
    // freezing the value here keeps a clear still in flight from reaching the slot
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_q[0] <= '0;
        end else begin
            cap_q[0].vec <= task_in.capture;
            cap_q[0].val <= cnt_q;
        end
    end

    generate
        for (genvar s = 1; s < CAP_STAGES; s++) begin : g_cap
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    cap_q[s] <= '0;
                end else begin
                    cap_q[s] <= cap_q[s-1];
                end
            end
        end
    endgenerate

    // last stage writes on the sixth edge; captures win over software writes
    assign cap_last      = cap_q[CAP_STAGES-1];
    assign cap_hit       = |cap_last.vec;
    assign slot_wr_ready = ~cap_hit;
    assign mem_wr_vec    = cap_hit ? cap_last.vec :
                           (slot_wr_en ? ltc_onehot(slot_wr_idx) : '0);
    assign mem_wr_data   = cap_hit ? cap_last.val : slot_wr_data;

    ltc_slot_mem #(
        .W  (LTC_CNT_W),
        .N  (LTC_SLOTS),
        .IW (LTC_SLOT_IDX_W)
    ) u_slots (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .wr_vec   (mem_wr_vec),
        .wr_data  (mem_wr_data),
        .rd_idx   (slot_rd_idx),
        .rd_data  (slot_rd_data),
        .all_flat (slots_flat)
    );

    // count read: hold the bus four cycles, then sample and answer
    // the count only moves on a synchronised edge, so the copy taken is never torn
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_st_q   <= LTC_RD_IDLE;
            rd_cnt_q  <= 3'h0;
            rd_data_q <= LTC_CNT_RST;
        end else begin
            unique case (rd_st_q)
                LTC_RD_IDLE: begin
                    rd_cnt_q <= 3'h0;
                    if (cnt_rd_req) begin
                        rd_st_q <= LTC_RD_STALL;
                    end
                end
                LTC_RD_STALL: begin
                    rd_cnt_q <= rd_cnt_q + 3'h1;
                    if (rd_cnt_q == LTC_RD_LAST) begin
                        rd_st_q   <= LTC_RD_DONE;
                        rd_data_q <= cnt_q;
                    end
                end
                LTC_RD_DONE: begin
                    rd_st_q <= LTC_RD_IDLE;
                end
                default: begin
                    rd_st_q <= LTC_RD_IDLE; // unused code, park in idle
                end
            endcase
        end
    end

    // stall and ack are plain decodes of the read state
    assign cnt_rd_stall = (rd_st_q == LTC_RD_STALL);
    assign cnt_rd_ack   = (rd_st_q == LTC_RD_DONE);
    assign cnt_rd_data  = rd_data_q;

    // status and event outputs
    assign evt_out            = evt_q;
    assign running            = run_lf_q;
    assign prescale_setting   = prescale_q;
    assign low_freq_request   = lf_req_q;
    assign low_freq_rc_source = lf_rc_q;

endmodule : ltc_top

//--- ltc_top_monitor.sv
`timescale 1ns/1ps
module ltc_top_monitor (
    // clock and reset
    input wire logic                          clk_sys,
    input wire logic                          sys_rst,
    // pins driven from outside
    input wire ltc_pkg::ltc_task_t            task_in,
    input wire logic                          prescale_we,
    input wire ltc_pkg::ltc_evt_t             event_gate_enable,
    input wire logic                          cnt_rd_req,
    // pins driven by the block
    input wire logic                          cnt_rd_stall,
    input wire logic                          cnt_rd_ack,
    input wire logic                          slot_wr_ready,
    input wire ltc_pkg::ltc_evt_t             evt_out,
    input wire logic                          fast_peripheral_clock_req,
    input wire logic                          high_freq_clock_req,
    input wire logic                          low_freq_request,
    input wire logic                          running,
    input wire logic [ltc_pkg::LTC_PRE_W-1:0] prescale_setting
);
    import ltc_pkg::*;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // set by a stop task, cleared by a lone start; events lag a cycle so we check one later
    logic stop_q;
    always_ff @(posedge clk_sys) begin
        stop_q <= sys_rst | task_in.stop | (stop_q & ~task_in.start);
    end

    property p_rd_go;
        cnt_rd_req && !cnt_rd_stall && !cnt_rd_ack |=> cnt_rd_stall;
    endproperty
    a_rd_go: assert property (p_rd_go) else $error("count read not taken");

    property p_rd_len;
        $rose(cnt_rd_stall) |-> cnt_rd_stall[*4] ##1 (!cnt_rd_stall && cnt_rd_ack);
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("count read stall length wrong");

    property p_ack_once;
        cnt_rd_ack |=> !cnt_rd_ack && !cnt_rd_stall;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("count read ack not a pulse");

    property p_clk_req;
        fast_peripheral_clock_req == (|evt_out) && high_freq_clock_req == (|evt_out);
    endproperty
    a_clk_req: assert property (p_clk_req) else $error("clock request without event");

    property p_gate;
        (evt_out & ~event_gate_enable & ~$past(event_gate_enable)
            & ~$past(event_gate_enable, 2)) == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("gated event fired");

    property p_pulse;
        evt_out != '0 |=> evt_out == '0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("event longer than one cycle");

    property p_stop;
        stop_q && $past(stop_q) |-> evt_out == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("event after stop");

    property p_req;
        task_in.start && !task_in.stop |-> ##[1:3] low_freq_request;
    endproperty
    a_req: assert property (p_req) else $error("low clock not requested");

    property p_pre;
        running && prescale_we |=> $stable(prescale_setting);
    endproperty
    a_pre: assert property (p_pre) else $error("prescale changed while running");

    property p_cap;
        task_in.capture != '0 |-> ##5 !slot_wr_ready;
    endproperty
    a_cap: assert property (p_cap) else $error("capture write not at cycle five");
endmodule : ltc_top_monitor

bind ltc_top ltc_top_monitor u_mon (
    .clk_sys, .sys_rst, .task_in, .prescale_we, .event_gate_enable, .cnt_rd_req,
    .cnt_rd_stall, .cnt_rd_ack, .slot_wr_ready, .evt_out, .fast_peripheral_clock_req,
    .high_freq_clock_req, .low_freq_request, .running, .prescale_setting
);

//--- tb_ltc_top.sv
`timescale 1ns/1ps
module tb_ltc_top;
    import ltc_pkg::*;

    // design pins
    logic clk_sys, low_freq_request, low_freq_rc_source, slot_wr_ready;
    logic cnt_rd_stall, cnt_rd_ack, fast_peripheral_clock_req, high_freq_clock_req, running;
    logic                 sys_rst = 1'b1, low_freq_clock = 1'b0, low_freq_running = 1'b0;
    logic                 prescale_we = 1'b0, slot_wr_en = 1'b0, cnt_rd_req = 1'b0;
    ltc_task_t            task_in = '0;
    ltc_evt_t             event_gate_enable = '0, evt_out;
    logic [LTC_PRE_W-1:0] prescale_wdata = '0, prescale_setting, pv;
    logic [1:0]           slot_wr_idx = '0, slot_rd_idx = '0;
    logic [LTC_CNT_W-1:0] slot_wr_data = '0, slot_rd_data, cnt_rd_data, v;
    // bench state
    logic [7:0] seed = 8'h60;
    integer     n_tick = 0, n_wrap = 0, n_cmp1 = 0, n_cmp3 = 0, base;
    int         n_errors = 0, checks = 0, n_rise = 0, lf_div = 0, pi;

    ltc_top uut (.clk_sys, .sys_rst, .low_freq_clock, .low_freq_running, .low_freq_request,
        .low_freq_rc_source, .task_in, .prescale_wdata, .prescale_we, .event_gate_enable,
        .slot_wr_en, .slot_wr_idx, .slot_wr_data, .slot_wr_ready, .slot_rd_idx, .slot_rd_data,
        .cnt_rd_req, .cnt_rd_stall, .cnt_rd_ack, .cnt_rd_data, .evt_out,
        .fast_peripheral_clock_req, .high_freq_clock_req, .running, .prescale_setting);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // slow pin near 32.8 kHz, phase unrelated to anything the design does
    always @(posedge clk_sys) begin
        if (lf_div == 151) begin
            lf_div <= 0;
            low_freq_clock <= ~low_freq_clock;
            n_rise <= n_rise + int'(!low_freq_clock);
        end else begin
            lf_div <= lf_div + 1;
        end
    end

    // tally event pulses away from the active edge
    always @(negedge clk_sys) begin
        if (!sys_rst) begin
            n_tick <= n_tick + evt_out.tick;
            n_wrap <= n_wrap + evt_out.wrap;
            n_cmp1 <= n_cmp1 + evt_out.cmp[1];
            n_cmp3 <= n_cmp3 + evt_out.cmp[3];
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // increments seen over n low-clock rises starting just after a tick
    function automatic int n_inc(input int n, input int div);
        return n / div;
    endfunction : n_inc

    task automatic results();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic tsk(input logic [7:0] t);
        task_in <= ltc_task_t'(t);
        @(posedge clk_sys);
        task_in <= '0;
    endtask : tsk

    task automatic pw(input logic [LTC_PRE_W-1:0] d);
        prescale_wdata <= d;
        prescale_we <= 1'b1;
        @(posedge clk_sys);
        prescale_we <= 1'b0;
    endtask : pw

    // wait for n more rises of the slow pin, then let the event path settle
    task automatic rises(input int n);
        int t, i;
        t = n_rise + n;
        i = 0;
        while (n_rise < t && i < n * 400 + 400) begin
            @(posedge clk_sys);
            i++;
        end
        if (n_rise < t) begin
            n_errors++;
            results();
        end
        tick(8);
    endtask : rises

    // align to just after a tick so the count is quiet for a whole divided period
    task automatic sync();
        int t, i;
        t = n_tick;
        i = 0;
        while (n_tick == t && i < 3000) begin
            @(posedge clk_sys);
            i++;
        end
        if (n_tick == t) begin
            n_errors++;
            results();
        end
        tick(4);
    endtask : sync

    task automatic rd(output logic [23:0] d);
        int i;
        cnt_rd_req <= 1'b1;
        @(posedge clk_sys);
        cnt_rd_req <= 1'b0;
        i = 0;
        do begin
            @(negedge clk_sys);
            i++;
        end while (cnt_rd_ack !== 1'b1 && i < 20);
        chk(24'(i), 24'h5);
        d = cnt_rd_data;
        @(posedge clk_sys);
    endtask : rd

    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk(24'(running), 24'h0);
        chk(24'(prescale_setting), 24'h0);
        seed = lfsr(seed);
        pv = 12'h1 + 12'(seed % 8'h3);
        pi = int'(pv) + 1;
        pw(pv);
        tick(2);
        chk(24'(prescale_setting), 24'(pv));
        // start with the slow clock reported idle and every event gated off
        tsk(8'h80);
        rises(3 * pi);
        chk(24'(low_freq_rc_source), 24'h1);
        chk(24'(low_freq_request), 24'h1);
        chk(24'(n_tick), 24'h0);
        pw(pv + 12'h1);
        tick(2);
        chk(24'(prescale_setting), 24'(pv));
        event_gate_enable <= '1;
        sync();
        base = n_tick;
        rises(4 * pi);
        chk(24'(n_tick - base), 24'(n_inc(4 * pi, pi)));
        // compare three ahead, capture slot 3 at the present count
        sync();
        rd(v);
        slot_wr_idx <= 2'h1;
        slot_wr_data <= v + 24'h3;
        slot_wr_en <= 1'b1;
        tsk(8'h08);
        slot_wr_en <= 1'b0;
        slot_rd_idx <= 2'h3;
        tick(9);
        chk(slot_rd_data, v);
        base = n_cmp1;
        rises(4 * pi);
        chk(24'(n_cmp1 - base), 24'h1);
        chk(24'(n_cmp3), 24'h0);
        // capture slot 0 together with clear
        sync();
        rd(v);
        tsk(8'h21);
        slot_rd_idx <= 2'h0;
        tick(9);
        chk(slot_rd_data, v);
        rises(2);
        rd(v);
        chk(v, 24'h0);
        tsk(8'h10);
        rises(1);
        rd(v);
        chk(v, LTC_NEAR_WRAP);
        base = n_wrap;
        rises(17 * pi);
        chk(24'(n_wrap - base), 24'h1);
        rd(v);
        chk(v, LTC_NEAR_WRAP + 24'(n_inc(17 * pi, pi)));
        // stop, then restart with the slow clock already running
        low_freq_running <= 1'b1;
        tsk(8'h40);
        tick(3);
        base = n_tick;
        rises(3 * pi);
        chk(24'(n_tick - base), 24'h0);
        chk(24'(running), 24'h0);
        tsk(8'h80);
        rises(2);
        chk(24'(low_freq_rc_source), 24'h0);
        results();
    end
endmodule : tb_ltc_top
